// ---- dsh_dev_end.sv ----
// Device end of the dual serial host port: UART and SPI slave with link lock
// ----------------------------------------------------------------------------
// What this block does and expects of the host
// - Lock to first link used until reset
// - Host ties unused link inputs to fixed levels
// - UART: 8 bits, LSB first, no parity, one stop
// - UART defaults to 115200 baud
// - UART rate never above 921600 baud
// - SPI mode 0, clock at most 20 MHz
// - Chip select active low frames transfers
// - Drive SPI output only while selected
// - Data-ready high while response waits
// - Reset low at least 20 us resets all
// - Host uses only one link at once
// ----------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module dsh_dev_end
(
  input  wire logic              mclk,      // System clock, 25 MHz
  input  wire logic              rst_n,     // Synchronous reset, active low
  dsh_link_if.dev                lnk,       // Pins to the host
  input  wire logic [11:0]       bit_cyc,   // UART bit period in mclk cycles, 0 = default
  output logic [7:0]             rx_data,   // Received byte
  output logic                   rx_valid,  // One-cycle pulse with rx_data
  input  wire logic [7:0]        tx_data,   // Response byte
  input  wire logic              tx_valid,  // Offer tx_data
  output logic                   tx_ready,  // tx_data taken when both high
  output dsh_pkg::dsh_link_t     link_sel   // Link in use
);
  import dsh_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    dsh_link_t   sel;
    logic [2:0]  urx_s;
    logic [2:0]  csn_s;
    logic [1:0]  pin_s;
    logic [1:0]  rtog_s;
    logic [1:0]  ack_s;
    logic        rx_seen;
    logic        tx_req;
    logic [7:0]  tx_hold;
    logic        pending;
    logic        ready;
    logic        tx_rdy;
    logic [7:0]  rx_data;
    logic        rx_valid;
    dsh_ustate_t r_st;
    logic [11:0] r_cnt;
    logic [2:0]  r_bit;
    logic [7:0]  r_sh;
    dsh_ustate_t t_st;
    logic [11:0] t_cnt;
    logic [2:0]  t_bit;
    logic [7:0]  t_sh;
    logic        txd;
  } dsh_dev_st_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] byte_v;
    logic       got;
  } dsh_rise_t;

  typedef struct packed {
    logic [1:0] req_s;
    logic [7:0] rx_hold;
    logic       rx_tog;
    logic       ack_tog;
    logic [7:0] sh;
  } dsh_fall_t;

  dsh_dev_st_t st, nx;
  dsh_rise_t   rs, rs_nx;
  dsh_fall_t   fl, fl_nx;
  logic [11:0] bc;
  logic        urx_fall;
  logic        csn_fall;
  logic        line;

  // --------------------------------------------------------------------------
  // SPI link domain
  // --------------------------------------------------------------------------
  // Rising edge samples data in; chip select high clears the bit count
  always_comb begin
    rs_nx        = rs;
    rs_nx.sh     = {rs.sh[5:0], lnk.mosi};
    rs_nx.cnt    = rs.cnt + 3'h1;
    rs_nx.got    = (rs.cnt == LAST_BIT);
    if (rs.cnt == LAST_BIT) begin
      rs_nx.byte_v = {rs.sh, lnk.mosi};
    end
  end

  // The link clock stops between frames, so deselect must clear it directly
  always_ff @(posedge lnk.spi_serial_clock or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      rs <= '0;
    end else begin
      rs <= rs_nx;
    end
  end

  // Falling edge shifts data out and hands whole bytes across
  always_comb begin
    fl_nx       = fl;
    fl_nx.req_s = {fl.req_s[0], st.tx_req};
    if (rs.got) begin
      fl_nx.rx_hold = rs.byte_v;
      fl_nx.rx_tog  = ~fl.rx_tog;
      // Next byte is loaded at the end of this one, so a response shows one byte late
      if (fl.req_s[1] != fl.ack_tog) begin
        fl_nx.sh      = st.tx_hold;
        fl_nx.ack_tog = ~fl.ack_tog;
      end else begin
        fl_nx.sh = SPI_FILL;
      end
    end else begin
      fl_nx.sh = {fl.sh[6:0], 1'b0};
    end
  end

  // Reset pin clears this side without waiting for link clock edges
  always_ff @(negedge lnk.spi_serial_clock or negedge lnk.rst_pin_n) begin
    if (!lnk.rst_pin_n) begin
      fl <= '0;
    end else begin
      fl <= fl_nx;
    end
  end

  // --------------------------------------------------------------------------
  // System clock domain
  // --------------------------------------------------------------------------
  // Zero bit period means factory rate; too short a period is clamped
  assign bc       = (bit_cyc == 12'h000) ? BIT_CYC_DEFAULT :
                    (bit_cyc < BIT_CYC_MIN) ? BIT_CYC_MIN : bit_cyc;
  assign urx_fall = st.urx_s[2] & ~st.urx_s[1];
  assign csn_fall = st.csn_s[2] & ~st.csn_s[1];
  assign line     = st.urx_s[1];

  always_comb begin
    nx          = st;
    nx.urx_s    = {st.urx_s[1:0], lnk.h2d};
    nx.csn_s    = {st.csn_s[1:0], lnk.cs_n};
    nx.pin_s    = {st.pin_s[0], lnk.rst_pin_n};
    nx.rtog_s   = {st.rtog_s[0], fl.rx_tog};
    nx.ack_s    = {st.ack_s[0], fl.ack_tog};
    nx.rx_valid = 1'b0;

    // First activity picks the link; nothing changes it until reset
    if (st.sel == LNK_NONE) begin
      if (urx_fall) begin
        nx.sel = LNK_UART;
      end else if (csn_fall) begin
        nx.sel = LNK_SPI;
      end
    end

    // UART receiver, mid-bit sampling
    case (st.r_st)
      UR_IDLE: begin
        if (urx_fall && st.sel != LNK_SPI) begin
          nx.r_st  = UR_START;
          nx.r_cnt = {1'b0, bc[11:1]};
        end
      end
      UR_START: begin
        if (st.r_cnt == 12'h000) begin
          nx.r_st  = line ? UR_IDLE : UR_DATA;
          nx.r_cnt = bc - 12'h001;
          nx.r_bit = 3'h0;
        end else begin
          nx.r_cnt = st.r_cnt - 12'h001;
        end
      end
      UR_DATA: begin
        if (st.r_cnt == 12'h000) begin
          nx.r_sh  = {line, st.r_sh[7:1]};
          nx.r_cnt = bc - 12'h001;
          nx.r_bit = st.r_bit + 3'h1;
          if (st.r_bit == LAST_BIT) begin
            nx.r_st = UR_STOP;
          end
        end else begin
          nx.r_cnt = st.r_cnt - 12'h001;
        end
      end
      UR_STOP: begin
        if (st.r_cnt == 12'h000) begin
          nx.r_st = UR_IDLE;
          if (line) begin
            nx.rx_data  = st.r_sh;
            nx.rx_valid = 1'b1;
          end
        end else begin
          nx.r_cnt = st.r_cnt - 12'h001;
        end
      end
      default: nx.r_st = UR_IDLE;
    endcase

    // SPI byte arrived; bytes of an unchosen link are dropped
    if (st.rtog_s[1] != st.rx_seen) begin
      nx.rx_seen = st.rtog_s[1];
      if (st.sel == LNK_SPI) begin
        nx.rx_data  = fl.rx_hold;
        nx.rx_valid = 1'b1;
      end
    end

    // Response byte parked for SPI is gone once the link side acknowledges
    if (st.pending && st.ack_s[1] == st.tx_req) begin
      nx.pending = 1'b0;
    end

    // UART transmitter
    case (st.t_st)
      UR_IDLE: begin
        if (tx_valid && st.tx_rdy) begin
          if (st.sel == LNK_UART) begin
            nx.t_st  = UR_START;
            nx.t_sh  = tx_data;
            nx.t_cnt = bc - 12'h001;
            nx.txd   = 1'b0;
          end else begin
            nx.tx_hold = tx_data;
            nx.pending = 1'b1;
            nx.tx_req  = ~st.tx_req;
          end
        end
      end
      UR_START: begin
        if (st.t_cnt == 12'h000) begin
          nx.t_st  = UR_DATA;
          nx.txd   = st.t_sh[0];
          nx.t_cnt = bc - 12'h001;
          nx.t_bit = 3'h0;
        end else begin
          nx.t_cnt = st.t_cnt - 12'h001;
        end
      end
      UR_DATA: begin
        if (st.t_cnt == 12'h000) begin
          nx.t_cnt = bc - 12'h001;
          if (st.t_bit == LAST_BIT) begin
            nx.t_st = UR_STOP;
            nx.txd  = 1'b1;
          end else begin
            nx.t_sh  = {1'b0, st.t_sh[7:1]};
            nx.txd   = st.t_sh[1];
            nx.t_bit = st.t_bit + 3'h1;
          end
        end else begin
          nx.t_cnt = st.t_cnt - 12'h001;
        end
      end
      UR_STOP: begin
        if (st.t_cnt == 12'h000) begin
          nx.t_st = UR_IDLE;
        end else begin
          nx.t_cnt = st.t_cnt - 12'h001;
        end
      end
      default: nx.t_st = UR_IDLE;
    endcase

    nx.tx_rdy = (nx.sel != LNK_NONE) && !nx.pending && (nx.t_st == UR_IDLE);
    nx.ready  = nx.pending && (nx.sel == LNK_SPI);

    // Either reset restarts the system clock side of the port; synchronisers keep running
    if (!rst_n || !st.pin_s[1]) begin
      nx         = '0;
      nx.urx_s   = {st.urx_s[1:0], lnk.h2d};
      nx.csn_s   = {st.csn_s[1:0], lnk.cs_n};
      nx.pin_s   = {st.pin_s[0], lnk.rst_pin_n};
      nx.rtog_s  = {st.rtog_s[0], fl.rx_tog};
      nx.ack_s   = {st.ack_s[0], fl.ack_tog};
      nx.rx_seen = st.rtog_s[1];
      nx.tx_req  = st.ack_s[1];
      nx.sel     = LNK_NONE;
      nx.r_st    = UR_IDLE;
      nx.t_st    = UR_IDLE;
      nx.txd     = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st <= nx;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rx_data       = st.rx_data;
  assign rx_valid      = st.rx_valid;
  assign tx_ready      = st.tx_rdy;
  assign link_sel      = st.sel;
  assign lnk.d2h       = st.txd;
  assign lnk.ready     = st.ready;
  assign lnk.miso      = fl.sh[7];
  // Enable follows the pin itself: a synchronised copy would be too late
  assign lnk.miso_oe_n = lnk.cs_n | (st.sel == LNK_UART);
endmodule : dsh_dev_end
`default_nettype wire

// ---- dsh_host_end.sv ----
// Host end of the dual serial host port: register-driven UART and SPI master
`timescale 1ns/1ns
`default_nettype none
module dsh_host_end
(
  input  wire logic        mclk,    // System clock, 25 MHz
  input  wire logic        rst_n,   // Synchronous reset, active low
  dsh_link_if.host         lnk,     // Pins to the device
  input  wire logic [2:0]  addr,    // Register index
  input  wire logic [15:0] wdata,   // Write data
  input  wire logic        wr,      // Write strobe
  input  wire logic        rd,      // Read strobe
  output logic [15:0]      rdata    // Read data, cycle after rd
);
  import dsh_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        use_spi;
    logic [11:0] baud;
    dsh_hstate_t hs;
    logic        rst_busy;
    logic [15:0] cnt;
    logic [3:0]  bit_n;
    logic [9:0]  sh;
    logic [7:0]  rxb;
    logic        rxv;
    logic [15:0] rdata;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        utx;
    logic        rst_pin_n;
    logic [1:0]  rdy_s;
    logic [1:0]  miso_s;
    logic [2:0]  urx_s;
    logic        hr_busy;
    logic [11:0] hr_cnt;
    logic [3:0]  hr_bit;
    logic [7:0]  hr_sh;
  } dsh_host_st_t;

  dsh_host_st_t st, nx;

  always_comb begin
    nx        = st;
    nx.rdy_s  = {st.rdy_s[0], lnk.ready};
    nx.miso_s = {st.miso_s[0], lnk.miso_line};
    nx.urx_s  = {st.urx_s[1:0], lnk.d2h};
    nx.rdata  = 16'h0000;

    // Register reads; reading the byte clears its flag unless a new one lands
    if (rd) begin
      case (addr)
        REG_CTRL:   nx.rdata = {15'h0000, st.use_spi};
        REG_BAUD:   nx.rdata = {4'h0, st.baud};
        REG_RXDATA: begin
          nx.rdata = {8'h00, st.rxb};
          nx.rxv   = 1'b0;
        end
        REG_STATUS: nx.rdata = {12'h000, st.rst_busy, st.rdy_s[1], st.rxv, st.hs != HS_IDLE};
        default:    nx.rdata = 16'h0000;
      endcase
    end

    // Register writes; link and reset change only while idle
    if (wr && st.hs == HS_IDLE && !st.rst_busy) begin
      case (addr)
        REG_CTRL: begin
          nx.use_spi = wdata[CTRL_SPI];
          if (wdata[CTRL_RST]) begin
            nx.rst_busy  = 1'b1;
            nx.rst_pin_n = 1'b0;
            nx.cnt       = RESET_CYC - 16'h0001;
          end
        end
        REG_BAUD: nx.baud = (wdata[11:0] < BIT_CYC_MIN) ? BIT_CYC_MIN : wdata[11:0];
        REG_TXDATA: begin
          if (!st.use_spi) begin
            nx.hs    = HS_UART;
            nx.sh    = {1'b1, wdata[7:0], 1'b0};
            nx.utx   = 1'b0;
            nx.cnt   = {4'h0, st.baud} - 16'h0001;
            nx.bit_n = 4'h0;
          end else if (!wdata[TX_READ_FLAG] || st.rdy_s[1]) begin
            nx.hs    = HS_SPI_LO;
            nx.cs_n  = 1'b0;
            nx.sh    = {2'b00, wdata[7:0]};
            nx.mosi  = wdata[7];
            nx.cnt   = {12'h000, SPI_HALF_CYC} - 16'h0001;
            nx.bit_n = 4'h0;
          end
        end
        default: nx.baud = st.baud;
      endcase
    end

    // Reset pulse on the module pin
    if (st.rst_busy) begin
      if (st.cnt == 16'h0000) begin
        nx.rst_busy  = 1'b0;
        nx.rst_pin_n = 1'b1;
      end else begin
        nx.cnt = st.cnt - 16'h0001;
      end
    end

    // Transfer sequencer
    case (st.hs)
      HS_IDLE: nx.hs = nx.hs;
      HS_UART: begin
        if (st.cnt == 16'h0000) begin
          nx.cnt = {4'h0, st.baud} - 16'h0001;
          if (st.bit_n == 4'h9) begin
            nx.hs = HS_IDLE;
          end else begin
            nx.sh    = {1'b1, st.sh[9:1]};
            nx.utx   = st.sh[1];
            nx.bit_n = st.bit_n + 4'h1;
          end
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      HS_SPI_LO: begin
        if (st.cnt == 16'h0000) begin
          nx.cnt = {12'h000, SPI_HALF_CYC} - 16'h0001;
          if (st.bit_n == 4'h8) begin
            nx.hs   = HS_IDLE;
            nx.cs_n = 1'b1;
            nx.rxb  = st.sh[7:0];
            nx.rxv  = 1'b1;
          end else begin
            nx.hs   = HS_SPI_HI;
            nx.sclk = 1'b1;
          end
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      HS_SPI_HI: begin
        if (st.cnt == 16'h0000) begin
          // Sample late in the high half: data changed a whole period ago
          nx.hs    = HS_SPI_LO;
          nx.sclk  = 1'b0;
          nx.sh    = {2'b00, st.sh[6:0], st.miso_s[1]};
          nx.mosi  = st.sh[6];
          nx.bit_n = st.bit_n + 4'h1;
          nx.cnt   = {12'h000, SPI_HALF_CYC} - 16'h0001;
        end else begin
          nx.cnt = st.cnt - 16'h0001;
        end
      end
      default: nx.hs = HS_IDLE;
    endcase

    // UART receiver, active only while the UART link is in use
    if (!st.hr_busy) begin
      if (!st.use_spi && st.urx_s[2] && !st.urx_s[1]) begin
        nx.hr_busy = 1'b1;
        nx.hr_cnt  = {1'b0, st.baud[11:1]};
        nx.hr_bit  = 4'h0;
      end
    end else if (st.hr_cnt == 12'h000) begin
      nx.hr_cnt = st.baud - 12'h001;
      nx.hr_bit = st.hr_bit + 4'h1;
      if (st.hr_bit == 4'h0) begin
        nx.hr_busy = ~st.urx_s[1];
      end else if (st.hr_bit == 4'h9) begin
        nx.hr_busy = 1'b0;
        if (st.urx_s[1]) begin
          nx.rxb = st.hr_sh;
          nx.rxv = 1'b1;
        end
      end else begin
        nx.hr_sh = {st.urx_s[1], st.hr_sh[7:1]};
      end
    end else begin
      nx.hr_cnt = st.hr_cnt - 12'h001;
    end

    // Unused link inputs sit at fixed idle levels from reset on
    if (!rst_n) begin
      nx           = '0;
      nx.rdy_s     = {st.rdy_s[0], lnk.ready};
      nx.miso_s    = {st.miso_s[0], lnk.miso_line};
      nx.urx_s     = {st.urx_s[1:0], lnk.d2h};
      nx.baud      = BIT_CYC_DEFAULT;
      nx.hs        = HS_IDLE;
      nx.cs_n      = 1'b1;
      nx.utx       = 1'b1;
      nx.rst_pin_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st <= nx;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rdata                = st.rdata;
  assign lnk.spi_serial_clock = st.sclk;
  assign lnk.cs_n             = st.cs_n;
  assign lnk.mosi             = st.mosi;
  assign lnk.h2d              = st.utx;
  assign lnk.rst_pin_n        = st.rst_pin_n;
endmodule : dsh_host_end
`default_nettype wire

// ---- dsh_link_asserts.sv ----
// Concurrent checks on the link pins between the two ends
`timescale 1ns/1ns
`default_nettype none
module dsh_link_asserts
  import dsh_pkg::*;
(
  input wire logic mclk,              // System clock
  input wire logic rst_n,             // Reset, active low
  input wire logic spi_serial_clock,  // SPI clock
  input wire logic cs_n,              // Chip select
  input wire logic mosi,              // Host data
  input wire logic miso_oe_n,         // Device drive enable, low
  input wire logic miso_line,         // Resolved device data
  input wire logic ready,             // Data ready
  input wire logic h2d,               // UART to device
  input wire logic d2h,               // UART to host
  input wire logic rst_pin_n          // Module reset pin
);
  logic [15:0] low_cnt_reg;  // Cycles the reset pin has been low
  logic [11:0] h2d_run_reg;  // Cycles h2d has kept its level
  logic [11:0] d2h_run_reg;  // Cycles d2h has kept its level
  logic        h2d_old_reg;  // h2d one cycle back
  logic        d2h_old_reg;  // d2h one cycle back

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Count the reset pin low time so its width can be judged at release
  always_ff @(posedge mclk) begin
    if (!rst_n || rst_pin_n) begin
      low_cnt_reg <= 16'h0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h1;
    end
  end

  // Level run lengths saturate, so a long idle line never wraps into a false short bit
  always_ff @(posedge mclk) begin
    h2d_old_reg <= h2d;
    d2h_old_reg <= d2h;
    if (!rst_n) begin
      h2d_run_reg <= 12'hfff;
      d2h_run_reg <= 12'hfff;
    end else begin
      h2d_run_reg <= (h2d != h2d_old_reg) ? 12'h001 : h2d_run_reg + {11'h000, h2d_run_reg != 12'hfff};
      d2h_run_reg <= (d2h != d2h_old_reg) ? 12'h001 : d2h_run_reg + {11'h000, d2h_run_reg != 12'hfff};
    end
  end

  property p_oe_off; (miso_oe_n == cs_n) && (!cs_n || miso_line); endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso enable does not follow select");
  property p_sclk_idle; cs_n |-> !spi_serial_clock; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock runs while deselected");
  property p_mode0; spi_serial_clock |-> $stable(mosi); endproperty
  a_mode0: assert property (p_mode0) else $error("mosi moved while clock high");
  property p_cs_frame; $fell(cs_n) |=> !cs_n [*8]; endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("select too short");
  property p_h2d_start; $changed(h2d) |-> h2d_run_reg >= BIT_CYC_MIN; endproperty
  a_h2d_start: assert property (p_h2d_start) else $error("host bit shorter than fastest rate");
  property p_d2h_start; $changed(d2h) |-> d2h_run_reg >= BIT_CYC_MIN; endproperty
  a_d2h_start: assert property (p_d2h_start) else $error("device bit shorter than fastest rate");
  property p_rst_len; $rose(rst_pin_n) |-> low_cnt_reg >= RESET_CYC; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
  property p_rst_ready; !rst_pin_n [*6] |-> !ready; endproperty
  a_rst_ready: assert property (p_rst_ready) else $error("ready kept in reset");

  c_spi: cover property ($fell(cs_n));
  c_uart: cover property ($fell(d2h));
  c_rst: cover property ($rose(rst_pin_n));
endmodule : dsh_link_asserts
`default_nettype wire

// ---- dsh_link_if.sv ----
// Pins between the host controller and the device port
`timescale 1ns/1ns
`default_nettype none
interface dsh_link_if;
  logic spi_serial_clock;  // Host-made SPI clock, mode 0
  logic cs_n;              // Chip select, active low
  logic mosi;              // Host to device SPI data
  logic miso;              // Device SPI data out
  logic miso_oe_n;         // Device drives miso while low
  logic miso_line;         // Resolved miso wire, pulled high when released
  logic ready;             // Device has response data
  logic h2d;               // UART host to device
  logic d2h;               // UART device to host
  logic rst_pin_n;         // Module reset from host, active low

  // Released line reads high as with a pull-up
  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport dev (input spi_serial_clock, cs_n, mosi, h2d, rst_pin_n,
               output miso, miso_oe_n, ready, d2h);
  modport host (output spi_serial_clock, cs_n, mosi, h2d, rst_pin_n,
                input miso_line, ready, d2h);
endinterface : dsh_link_if
`default_nettype wire

// ---- dsh_pkg.sv ----
// Shared constants and types for the dual serial host port
package dsh_pkg;
  // --------------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------------
  localparam int          MCLK_HZ         = 25_000_000;
  localparam int          MCLK_NS         = 1_000_000_000 / MCLK_HZ;
  localparam int          BAUD_DEFAULT    = 115200;
  localparam int          BAUD_MAX        = 921600;
  localparam logic [11:0] BIT_CYC_DEFAULT = 12'(MCLK_HZ / BAUD_DEFAULT);
  // Shortest legal bit rounds up so the rate never passes the maximum
  localparam logic [11:0] BIT_CYC_MIN     = 12'((MCLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  // Half serial clock period; four cycles leave room for the data-in synchroniser
  localparam logic [3:0]  SPI_HALF_CYC    = 4'h4;
  localparam int          RESET_NS        = 20_000;
  localparam logic [15:0] RESET_CYC       = 16'((RESET_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [2:0]  LAST_BIT        = 3'h7;
  localparam logic [7:0]  SPI_FILL        = 8'h00;

  // --------------------------------------------------------------------------
  // Host controller registers
  // --------------------------------------------------------------------------
  localparam logic [2:0]  REG_CTRL        = 3'h0;
  localparam logic [2:0]  REG_BAUD        = 3'h1;
  localparam logic [2:0]  REG_TXDATA      = 3'h2;
  localparam logic [2:0]  REG_RXDATA      = 3'h3;
  localparam logic [2:0]  REG_STATUS      = 3'h4;
  localparam int          CTRL_SPI        = 0;
  localparam int          CTRL_RST        = 1;
  localparam int          TX_READ_FLAG    = 8;
  localparam int          ST_BUSY         = 0;
  localparam int          ST_RXV          = 1;
  localparam int          ST_READY        = 2;
  localparam int          ST_RESET        = 3;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LNK_NONE = 3'b001,
    LNK_UART = 3'b010,
    LNK_SPI  = 3'b100
  } dsh_link_t;

  typedef enum logic [3:0] {
    UR_IDLE  = 4'b0001,
    UR_START = 4'b0010,
    UR_DATA  = 4'b0100,
    UR_STOP  = 4'b1000
  } dsh_ustate_t;

  typedef enum logic [3:0] {
    HS_IDLE   = 4'b0001,
    HS_UART   = 4'b0010,
    HS_SPI_LO = 4'b0100,
    HS_SPI_HI = 4'b1000
  } dsh_hstate_t;
endpackage : dsh_pkg

// ---- tb.sv ----
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dsh_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tx_valid = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0, rdata, v;
  logic [11:0] bit_cyc = 12'h0;
  logic [7:0]  tx_data = 8'h0, rx_data;
  logic        rx_valid, tx_ready;
  dsh_link_t   link_sel;
  int          n_errors = 0, checked = 0, n_rx = 0, n0 = 0, cyc = 0;
  // Bit period, byte to device, byte to host
  logic [27:0] rows [3] = '{{BIT_CYC_DEFAULT, 16'h0180}, {BIT_CYC_MIN, 16'hfe7f}, {12'h040, 16'h5aa5}};

  dsh_link_if lnk ();
  dsh_host_end dsh_host_end_i (.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  dsh_dev_end dsh_dev_end_i (.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .bit_cyc(bit_cyc), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .link_sel(link_sel));
  dsh_link_asserts dsh_link_asserts_i (.mclk(mclk), .rst_n(rst_n), .spi_serial_clock(lnk.spi_serial_clock),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso_oe_n(lnk.miso_oe_n), .miso_line(lnk.miso_line), .ready(lnk.ready),
    .h2d(lnk.h2d), .d2h(lnk.d2h), .rst_pin_n(lnk.rst_pin_n));

  always #20 mclk = ~mclk;
  // Count device receive pulses; cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) n_rx <= n_rx + 1;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic wait_st(input int b, input logic e);
    for (int i = 0; i < 3000; i++) begin
      rd_reg(REG_STATUS);
      if (v[b] === e) return;
    end
    n_errors++;
    $display("[FAIL] t=%0t status bit %0d got=%h exp=%h", $time, b, v[b], e);
  endtask : wait_st
  // Writes are dropped while busy, so wait for idle first
  task automatic send_tx(input logic [15:0] d);
    wait_st(ST_BUSY, 1'b0);
    wr_reg(REG_TXDATA, d);
  endtask : send_tx
  task automatic wait_rx(input logic [7:0] e);
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk);
      if (rx_valid === 1'b1) break;
    end
    chk(16'(rx_valid), 16'h1);
    chk(16'(rx_data), 16'(e));
  endtask : wait_rx
  task automatic dev_send(input logic [7:0] b);
    @(posedge mclk);
    tx_data <= b;
    tx_valid <= 1'b1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk);
      if (tx_ready === 1'b1) break;
    end
    tx_valid <= 1'b0;
  endtask : dev_send
  task automatic host_rx(input logic [7:0] e);
    wait_st(ST_RXV, 1'b1);
    rd_reg(REG_RXDATA);
    chk(16'(v[7:0]), 16'(e));
  endtask : host_rx
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Main sequence: UART rows, then reset pin, SPI lock and refusal
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(REG_BAUD);
    chk(v, 16'(BIT_CYC_DEFAULT));
    chk(16'(link_sel), 16'(LNK_NONE));
    $display("reset test done");
    foreach (rows[i]) begin
      wr_reg(REG_BAUD, 16'(rows[i][27:16]));
      bit_cyc <= rows[i][27:16];
      send_tx(16'(rows[i][15:8]));
      wait_rx(rows[i][15:8]);
      dev_send(rows[i][7:0]);
      host_rx(rows[i][7:0]);
      chk(16'(link_sel), 16'(LNK_UART));
      $display("uart row %0d done", i);
    end
    wr_reg(REG_CTRL, 16'h0002);
    wait_st(ST_RESET, 1'b0);
    repeat (4) @(posedge mclk);
    chk(16'(link_sel), 16'(LNK_NONE));
    $display("reset pin test done");
    wr_reg(REG_CTRL, 16'h0001);
    send_tx(16'h00a5);
    wait_rx(8'ha5);
    chk(16'(link_sel), 16'(LNK_SPI));
    host_rx(SPI_FILL);
    rd_reg(REG_STATUS);
    chk(16'(v[ST_READY]), 16'h0);
    dev_send(8'h3c);
    wait_st(ST_READY, 1'b1);
    chk(16'(v[ST_READY]), 16'h1);
    send_tx(16'h0100);
    host_rx(SPI_FILL);
    send_tx(16'h0000);
    host_rx(8'h3c);
    rd_reg(REG_STATUS);
    chk(16'(v[ST_READY]), 16'h0);
    wr_reg(REG_TXDATA, 16'h0100);
    rd_reg(REG_STATUS);
    chk(16'(v[ST_BUSY]), 16'h0);
    $display("spi test done");
    n0 = n_rx;
    wr_reg(REG_CTRL, 16'h0000);
    send_tx(16'h0055);
    wait_st(ST_BUSY, 1'b0);
    repeat (100) @(posedge mclk);
    chk(16'(n_rx - n0), 16'h0);
    chk(16'(link_sel), 16'(LNK_SPI));
    $display("lock test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
